//--- hdl/mpm_pkg.sv
// Package with power-mode codes, register windows, widths and timing constants.
package mpm_pkg;
    // Mode-select pin codes, written {mode_select_high, mode_select_low}.
    typedef enum logic [1:0] {
        MPM_IDLE = 2'b00,
        MPM_DETECT = 2'b01,
        MPM_PARTIAL = 2'b10,
        MPM_NORMAL = 2'b11
    } mpm_mode_t;

    // Partial-measurement register window and special registers.
    localparam logic [9:0] PM_WIN_LO = 10'h014;
    localparam logic [9:0] PM_WIN_HI = 10'h01d;
    localparam logic [9:0] SPECIAL_00 = 10'h000;
    localparam logic [9:0] SPECIAL_01 = 10'h001;
    localparam logic [9:0] SPECIAL_03 = 10'h003;
    localparam logic [9:0] SPECIAL_07 = 10'h007;
    localparam logic [9:0] SPECIAL_0E = 10'h00e;
    localparam logic [9:0] SPECIAL_0F = 10'h00f;

    // Default values after reset.
    localparam logic [5:0] DET_CTRL_RESET = 6'h3f;
    localparam logic PM_CFG_RESET = 1'b0;
    localparam logic [15:0] THRESH_RESET = 16'h0000;

    // Line cycle length in estimator samples (8 kHz samples at 50 Hz).
    localparam int LINE_CYCLE_SAMPLES = 160;

    // Controller register offsets (APB byte addresses).
    localparam logic [7:0] CTL_MODE_OFS = 8'h00;
    localparam logic [7:0] CTL_STAT_OFS = 8'h04;
    localparam logic [7:0] CTL_RESULT_OFS = 8'h08;
    localparam logic [7:0] CTL_DETCFG_OFS = 8'h0c;
    localparam logic [7:0] CTL_THRESH_OFS = 8'h10;
    localparam logic [31:0] CTL_MODE_RESET = 32'h0000_0000;

    // Park count loaded between two non-idle modes; the pins stay in idle for one cycle more than this.
    localparam int IDLE_PARK_CYCLES = 4;
endpackage

//--- hdl/mpm_if.sv
// Interface that joins the metering device end to its controller end.
`timescale 1ns/1ns
interface mpm_if;
    logic mode_select_high;
    logic mode_select_low;
    logic first_interrupt_out;
    logic second_interrupt_out;
    logic [5:0] detector_control;
    logic partial_meas_config;
    logic [15:0] threshold;
    logic osc_drive_out;

    modport device (
        input mode_select_high,
        input mode_select_low,
        input detector_control,
        input partial_meas_config,
        input threshold,
        output first_interrupt_out,
        output second_interrupt_out,
        output osc_drive_out
    );
    modport host (
        output mode_select_high,
        output mode_select_low,
        output detector_control,
        output partial_meas_config,
        output threshold,
        input first_interrupt_out,
        input second_interrupt_out,
        input osc_drive_out
    );
endinterface

//--- hdl/mpm_device.sv
// Device end: power-mode decode, pin gating, current detector and estimator.
//
// Function
// - Two mode pins select the power mode.
// - Normal runs everything except current detector.
// - Idle stops functions, oscillator output held low.
// - Idle forces zero-cross, pulse, warning, interrupts low.
// - Idle turns serial pins and DMA input.
// - Controller drives valid levels on inputs.
// - Mode pins stay working in idle.
// - Detection mode enables low-power current comparators.
// - Any phase over threshold latches first interrupt.
// - All phases over threshold latch second interrupt.
// - Entering or leaving detection clears detection interrupts.
// - Controller programs thresholds in normal mode.
// - Per-phase positive and negative comparators, enableable.
// - Each comparator powers down via control bit.
// - Detection holds pins idle except interrupts, mode, oscillator output.
// - Partial mode gates converters, measures one cycle.
// - Partial measurement done raises first interrupt.
// - Partial mode restricts register access window.
// - Mode changes always pass through idle.
// - Estimator runs in partial and normal modes.
// - RMS result unsigned, mean result signed.
// - Controller polls detection and measurement periodically.
`timescale 1ns/1ns
module mpm_device #(
    parameter int SAMPLE_W = 16,
    parameter int CYCLE_SAMPLES = mpm_pkg::LINE_CYCLE_SAMPLES
) (
    input wire logic pclk,
    input wire logic presetn,
    mpm_if.device link,
    input wire logic [2:0] phase_pos_over,
    input wire logic [2:0] phase_neg_over,
    input wire logic sample_valid,
    input wire logic signed [SAMPLE_W-1:0] sample_data,
    input wire logic [9:0] reg_addr,
    input wire logic zero_cross_core,
    input wire logic energy_pulse_core,
    input wire logic warning_core,
    input wire logic [3:0] serial_oe_core,
    output logic reg_access_ok,
    output logic zero_cross_out,
    output logic energy_pulse_out,
    output logic warning_out,
    output logic [3:0] serial_oe_n,
    output logic dma_req_is_input,
    output logic function_run,
    output logic detector_run,
    output logic converters_run,
    output logic estimator_run,
    output logic [5:0] comparator_power,
    output logic [2*SAMPLE_W-1:0] est_result,
    output logic est_done
);
    // Accumulator width: a full square of one sample fits without loss.
    localparam int ACC_W = 2 * SAMPLE_W;

    typedef struct packed {
        logic [1:0] mode_s1;
        logic [1:0] mode;
        logic [1:0] mode_prev;
        logic irq_first;
        logic irq_second;
        logic done;
        logic [15:0] count;
        logic [2*SAMPLE_W-1:0] acc;
        logic [2*SAMPLE_W-1:0] result;
    } mpm_dev_state_t;

    mpm_dev_state_t st_reg;
    mpm_dev_state_t st_next;
    logic mode_change;
    logic [2:0] phase_hit;
    logic [2*SAMPLE_W-1:0] square;

    // Square for RMS accumulation; both operands are sign-extended first so no bit is lost.
    assign square = ACC_W'(sample_data) * ACC_W'(sample_data);

    // One comparator hit per phase: only powered comparators count.
    // per-phase comparators
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            phase_hit[i] = (phase_pos_over[i] & link.detector_control[2*i]) |
                           (phase_neg_over[i] & link.detector_control[2*i+1]);
        end
    end

    // Next-state logic for mode tracking, interrupts and the estimator.
    always_comb begin
        st_next = st_reg;
        st_next.mode_s1 = {link.mode_select_high, link.mode_select_low};
        st_next.mode = st_reg.mode_s1;
        st_next.mode_prev = st_reg.mode;
        // Only the second stage and its delayed copy are compared, so the first
        // stage, which may still be settling, never reaches any other logic.
        mode_change = (st_reg.mode != st_reg.mode_prev);
        if (mode_change) begin
            st_next.irq_first = 1'b0;
            st_next.irq_second = 1'b0;
            st_next.done = 1'b0;
            st_next.count = '0;
            st_next.acc = '0;
        end else if (st_reg.mode == mpm_pkg::MPM_DETECT) begin
            if (|phase_hit) begin
                st_next.irq_first = 1'b1;
            end
            if (&phase_hit) begin
                st_next.irq_second = 1'b1;
            end
        end else if (st_reg.mode == mpm_pkg::MPM_PARTIAL ||
                     st_reg.mode == mpm_pkg::MPM_NORMAL) begin
            // The result is the raw sum: scaling to RMS or mean is left to software,
            // which keeps the always-on datapath small.
            // estimator runs here
            if (sample_valid && !st_reg.done) begin
                if (link.partial_meas_config) begin
                    st_next.acc = st_reg.acc + ACC_W'(sample_data);
                end else begin
                    st_next.acc = st_reg.acc + square;
                end
                // The counter is 16 bits wide, so CYCLE_SAMPLES may not exceed 65536.
                if (st_reg.count == 16'(CYCLE_SAMPLES - 1)) begin
                    st_next.done = 1'b1;
                    st_next.result = st_next.acc;
                end else begin
                    st_next.count = st_reg.count + 16'h0001;
                end
            end
            if (st_reg.mode == mpm_pkg::MPM_PARTIAL && st_reg.done) begin
                st_next.irq_first = 1'b1;
            end
        end
    end

    // State register; asynchronous reset to idle with everything clear.
    // Every synchroniser stage resets to the idle code, so no false mode edge follows reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Pin gating per mode; idle and detection park the core outputs.
    always_comb begin
        function_run = (st_reg.mode == mpm_pkg::MPM_NORMAL);
        detector_run = (st_reg.mode == mpm_pkg::MPM_DETECT);
        converters_run = (st_reg.mode == mpm_pkg::MPM_NORMAL);
        estimator_run = (st_reg.mode == mpm_pkg::MPM_NORMAL) ||
                        (st_reg.mode == mpm_pkg::MPM_PARTIAL);
        comparator_power = detector_run ? link.detector_control : 6'h00;
        zero_cross_out = function_run & zero_cross_core;
        energy_pulse_out = function_run & energy_pulse_core;
        warning_out = function_run & warning_core;
        serial_oe_n = function_run ? ~serial_oe_core : 4'hf;
        dma_req_is_input = 1'b1;
        est_done = st_reg.done;
        est_result = st_reg.result;
    end

    // Interrupts are low in idle and normal; oscillator output low in idle.
    // oscillator parked low
    assign link.osc_drive_out = (st_reg.mode != mpm_pkg::MPM_IDLE) & pclk_gate();
    assign link.first_interrupt_out = st_reg.irq_first &
        (st_reg.mode == mpm_pkg::MPM_DETECT || st_reg.mode == mpm_pkg::MPM_PARTIAL);
    assign link.second_interrupt_out = st_reg.irq_second &
        (st_reg.mode == mpm_pkg::MPM_DETECT);

    // Oscillator run indication; the pin model only needs its level.
    // A real clock gate would replace this stub; it stays high while powered.
    function automatic logic pclk_gate();
        return 1'b1;
    endfunction

    // Register access limit; only partial mode narrows the window.
    // Idle and detection refuse every access, since the core is unpowered there.
    // partial access window
    always_comb begin
        if (st_reg.mode == mpm_pkg::MPM_PARTIAL) begin
            reg_access_ok = (reg_addr >= mpm_pkg::PM_WIN_LO && reg_addr <= mpm_pkg::PM_WIN_HI) ||
                            reg_addr == mpm_pkg::SPECIAL_00 || reg_addr == mpm_pkg::SPECIAL_01 ||
                            reg_addr == mpm_pkg::SPECIAL_03 || reg_addr == mpm_pkg::SPECIAL_07 ||
                            reg_addr == mpm_pkg::SPECIAL_0E || reg_addr == mpm_pkg::SPECIAL_0F;
        end else begin
            reg_access_ok = (st_reg.mode == mpm_pkg::MPM_NORMAL);
        end
    end
endmodule

//--- hdl/mpm_host.sv
// Controller end: APB registers command the mode pins and report interrupts.
`timescale 1ns/1ns
module mpm_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    mpm_if.host link
);
    typedef enum logic [1:0] {
        MPM_H_STEADY = 2'b00,
        MPM_H_PARK = 2'b01
    } mpm_host_fsm_t;

    typedef struct packed {
        mpm_host_fsm_t fsm;
        logic [1:0] target;
        logic [1:0] pins;
        logic [7:0] park_cnt;
        logic [5:0] det_ctrl;
        logic pm_cfg;
        logic [15:0] thresh;
        logic [31:0] rdata;
        logic err;
    } mpm_host_state_t;

    mpm_host_state_t st_reg;
    mpm_host_state_t st_next;
    logic access;

    assign access = psel & penable;

    // APB slave plus mode sequencer.
    always_comb begin
        st_next = st_reg;
        st_next.err = 1'b0;
        if (psel && !penable) begin
            st_next.err = 1'b0;
            unique case (paddr)
                mpm_pkg::CTL_MODE_OFS: st_next.rdata = {30'h0, st_reg.target};
                mpm_pkg::CTL_STAT_OFS: st_next.rdata = {27'h0, st_reg.pins,
                    link.osc_drive_out, link.second_interrupt_out, link.first_interrupt_out};
                mpm_pkg::CTL_RESULT_OFS: st_next.rdata = {31'h0, st_reg.pm_cfg};
                mpm_pkg::CTL_DETCFG_OFS: st_next.rdata = {26'h0, st_reg.det_ctrl};
                mpm_pkg::CTL_THRESH_OFS: st_next.rdata = {16'h0, st_reg.thresh};
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.err = 1'b1;
                end
            endcase
            // Config writes are refused unless the pins select normal and no mode
            // change is pending, so a write can never land outside normal mode.
            // program in normal
            if (pwrite && (paddr == mpm_pkg::CTL_DETCFG_OFS ||
                           paddr == mpm_pkg::CTL_THRESH_OFS ||
                           paddr == mpm_pkg::CTL_RESULT_OFS) &&
                (st_reg.pins != mpm_pkg::MPM_NORMAL ||
                 st_reg.target != mpm_pkg::MPM_NORMAL)) begin
                st_next.err = 1'b1;
            end
        end else if (access) begin
            st_next.err = st_reg.err;
            // Writes take effect at the access edge only, and only if not refused.
            if (pwrite && !st_reg.err) begin
                if (paddr == mpm_pkg::CTL_MODE_OFS) begin
                    st_next.target = pwdata[1:0];
                end else if (paddr == mpm_pkg::CTL_DETCFG_OFS) begin
                    st_next.det_ctrl = pwdata[5:0];
                end else if (paddr == mpm_pkg::CTL_THRESH_OFS) begin
                    st_next.thresh = pwdata[15:0];
                end else if (paddr == mpm_pkg::CTL_RESULT_OFS) begin
                    st_next.pm_cfg = pwdata[0];
                end
            end
        end
        // Any change between two non-idle modes first parks in idle.
        // route through idle
        unique case (st_reg.fsm)
            MPM_H_STEADY: begin
                if (st_reg.target != st_reg.pins) begin
                    if (st_reg.pins == mpm_pkg::MPM_IDLE ||
                        st_reg.target == mpm_pkg::MPM_IDLE) begin
                        st_next.pins = st_reg.target;
                    end else begin
                        st_next.pins = mpm_pkg::MPM_IDLE;
                        st_next.park_cnt = 8'(mpm_pkg::IDLE_PARK_CYCLES);
                        st_next.fsm = MPM_H_PARK;
                    end
                end
            end
            MPM_H_PARK: begin
                if (st_reg.park_cnt == 8'h00) begin
                    st_next.pins = st_reg.target;
                    st_next.fsm = MPM_H_STEADY;
                end else begin
                    st_next.park_cnt = st_reg.park_cnt - 8'h01;
                end
            end
        endcase
    end

    // State register under asynchronous reset; pins start in idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.det_ctrl <= mpm_pkg::DET_CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Mode pins and configuration always driven with valid levels.
    // valid levels driven
    assign link.mode_select_high = st_reg.pins[1];
    assign link.mode_select_low = st_reg.pins[0];
    assign link.detector_control = st_reg.det_ctrl;
    assign link.partial_meas_config = st_reg.pm_cfg;
    assign link.threshold = st_reg.thresh;
    assign pready = 1'b1;
    assign prdata = st_reg.rdata;
    assign pslverr = access & st_reg.err;
endmodule

//--- tb/mpm_asserts.sv
// Concurrent checks on the mode pins, interrupt lines and oscillator output.
`timescale 1ns/1ns
module mpm_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mode_select_high,
    input wire logic mode_select_low,
    input wire logic first_interrupt_out,
    input wire logic second_interrupt_out,
    input wire logic [5:0] detector_control,
    input wire logic partial_meas_config,
    input wire logic [15:0] threshold,
    input wire logic osc_drive_out
);
    logic [1:0] pins;
    // Pin pair as the device decodes it.
    assign pins = {mode_select_high, mode_select_low};
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // The device sees the pins two edges late, so three samples mean a settled mode.
    sequence settled(logic [1:0] m);
        (pins == m) [*3];
    endsequence
    sequence busy_to_idle;
        ($past(pins) != 2'b00) && (pins == 2'b00);
    endsequence
    sequence held_irq(logic [1:0] m, logic irq);
        settled(m) ##0 irq ##1 (pins == m);
    endsequence
    chk_osc_idle_low: assert property (settled(2'b00) |-> !osc_drive_out)
        else $error("oscillator output high in idle");
    chk_idle_irq_low: assert property (
        settled(2'b00) |-> !first_interrupt_out && !second_interrupt_out)
        else $error("interrupt high in idle");
    chk_partial_no_second: assert property (settled(2'b10) |-> !second_interrupt_out)
        else $error("second interrupt high in partial mode");
    chk_no_direct_hop: assert property (
        ($past(pins) != 2'b00 && pins != 2'b00) |-> pins == $past(pins))
        else $error("direct hop between busy modes");
    chk_idle_park_len: assert property (busy_to_idle |-> (pins == 2'b00) [*4])
        else $error("idle park too short");
    chk_second_needs_first: assert property (
        second_interrupt_out |-> first_interrupt_out)
        else $error("second interrupt without first");
    chk_first_held: assert property (
        held_irq(2'b01, first_interrupt_out) |-> first_interrupt_out)
        else $error("first interrupt dropped in detection");
    chk_second_held: assert property (
        held_irq(2'b01, second_interrupt_out) |-> second_interrupt_out)
        else $error("second interrupt dropped in detection");
    chk_irq_clear_change: assert property (
        $changed(pins) |-> ##[1:4] (!first_interrupt_out && !second_interrupt_out))
        else $error("interrupts not cleared on mode change");
    // A configuration write may only land while the pins select normal mode.
    chk_cfg_frozen: assert property (
        $past(pins) != 2'b11 |-> $stable({detector_control, partial_meas_config, threshold}))
        else $error("configuration changed outside normal mode");
endmodule

//--- tb/metering_power_mode_control_tb.sv
// Bench joining both ends of the power-mode block, checked against a small model.
`timescale 1ns/1ns
module metering_power_mode_control_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, est_result;
    logic pready, pslverr, err, sv = 1'b0, zxc = 1'b0, epc = 1'b0, wnc = 1'b0;
    logic [2:0] posov = 3'h0, negov = 3'h0;
    logic signed [15:0] sd = 16'h0;
    logic [9:0] ra = 10'h0;
    logic [3:0] soec = 4'h0, soen;
    logic ok, zxo, epo, wno, dmai, frun, drun, crun, erun, edone;
    logic [5:0] cpwr;
    logic [1:0] pins;
    int n_errors = 0, cmp_count = 0, acc;
    assign pins = {u_mpm_if.mode_select_high, u_mpm_if.mode_select_low};
    // Free-running bus clock, 4 ns period.
    always #2 pclk = ~pclk;
    mpm_if u_mpm_if ();
    mpm_device #(.SAMPLE_W(16), .CYCLE_SAMPLES(8)) u_mpm_device (.pclk(pclk), .presetn(presetn),
        .link(u_mpm_if.device), .phase_pos_over(posov), .phase_neg_over(negov), .sample_valid(sv),
        .sample_data(sd), .reg_addr(ra), .zero_cross_core(zxc), .energy_pulse_core(epc),
        .warning_core(wnc), .serial_oe_core(soec), .reg_access_ok(ok), .zero_cross_out(zxo),
        .energy_pulse_out(epo), .warning_out(wno), .serial_oe_n(soen), .dma_req_is_input(dmai),
        .function_run(frun), .detector_run(drun), .converters_run(crun), .estimator_run(erun),
        .comparator_power(cpwr), .est_result(est_result), .est_done(edone));
    mpm_host u_mpm_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(u_mpm_if.host));
    mpm_asserts u_mpm_asserts (.pclk(pclk), .presetn(presetn),
        .mode_select_high(u_mpm_if.mode_select_high), .mode_select_low(u_mpm_if.mode_select_low),
        .first_interrupt_out(u_mpm_if.first_interrupt_out),
        .second_interrupt_out(u_mpm_if.second_interrupt_out),
        .detector_control(u_mpm_if.detector_control),
        .partial_meas_config(u_mpm_if.partial_meas_config), .threshold(u_mpm_if.threshold),
        .osc_drive_out(u_mpm_if.osc_drive_out));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends the wait for a slave that never answers.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic irqs(input logic [1:0] exp);
        check({u_mpm_if.second_interrupt_out, u_mpm_if.first_interrupt_out}, exp);
    endtask
    // Drives the comparator levels at a rising edge, then checks both interrupts.
    task automatic comp(input logic [2:0] p, input logic [2:0] n, input logic [1:0] exp);
        @(posedge pclk);
        posov <= p;
        negov <= n;
        repeat (3) @(negedge pclk);
        irqs(exp);
    endtask
    // Commands a mode and waits until the device has seen the pins.
    task automatic go_mode(input mpm_pkg::mpm_mode_t m);
        apb(1'b1, mpm_pkg::CTL_MODE_OFS, {30'h0, m});
        while (pins !== m) begin
            @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask
    // Random core levels must only reach the pins in normal mode.
    task automatic gate(input logic nrm);
        @(posedge pclk);
        {zxc, epc, wnc, soec} <= 7'($urandom);
        @(negedge pclk);
        check({zxo, epo, wno, dmai}, {zxc & nrm, epc & nrm, wnc & nrm, 1'b1});
        check(soen, nrm ? 4'(~soec) : 4'hf);
    endtask
    task automatic feed(input logic mean);
        int v;
        acc = 0;
        for (int i = 0; i < 8; i++) begin
            v = int'($urandom_range(2000)) - 1000;
            acc += mean ? v : v * v;
            @(posedge pclk);
            sv <= 1'b1;
            sd <= 16'(v);
            @(posedge pclk);
            sv <= 1'b0;
        end
        while (edone !== 1'b1) begin
            @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(est_result, 32'(acc));
    endtask
    // Cuts a hang short.
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    // Main sequence.
    initial begin
        static logic [7:0] ofs [4] = '{mpm_pkg::CTL_MODE_OFS, mpm_pkg::CTL_DETCFG_OFS,
            mpm_pkg::CTL_THRESH_OFS, mpm_pkg::CTL_RESULT_OFS};
        static logic [31:0] rv [4] = '{mpm_pkg::CTL_MODE_RESET, 32'(mpm_pkg::DET_CTRL_RESET),
            32'(mpm_pkg::THRESH_RESET), 32'(mpm_pkg::PM_CFG_RESET)};
        logic [15:0] th;
        void'($urandom(32'hed6a));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            check(rd, rv[i]);
        end
        apb(1'b0, 8'h20, 32'h0);
        check(err, 1'b1);
        apb(1'b0, mpm_pkg::CTL_STAT_OFS, 32'h0);
        check(rd[4:0], 5'h00);
        gate(1'b0);
        check({u_mpm_if.osc_drive_out, frun, cpwr}, 8'h00);
        go_mode(mpm_pkg::MPM_NORMAL);
        gate(1'b1);
        check({frun, drun, erun, cpwr}, 9'h140);
        th = 16'($urandom);
        apb(1'b1, mpm_pkg::CTL_THRESH_OFS, {16'h0, th});
        apb(1'b0, mpm_pkg::CTL_THRESH_OFS, 32'h0);
        check(rd, {16'h0, th});
        apb(1'b1, mpm_pkg::CTL_DETCFG_OFS, 32'h3e);
        go_mode(mpm_pkg::MPM_DETECT);
        check({drun, cpwr}, 7'h7e);
        gate(1'b0);
        apb(1'b1, mpm_pkg::CTL_DETCFG_OFS, 32'h3f);
        check(err, 1'b1);
        comp(3'b001, 3'b000, 2'b00);
        comp(3'b001, 3'b001, 2'b01);
        comp(3'b110, 3'b001, 2'b11);
        comp(3'b000, 3'b000, 2'b11);
        go_mode(mpm_pkg::MPM_IDLE);
        irqs(2'b00);
        for (int m = 1; m >= 0; m--) begin
            go_mode(mpm_pkg::MPM_NORMAL);
            apb(1'b1, mpm_pkg::CTL_RESULT_OFS, 32'(m));
            go_mode(mpm_pkg::MPM_PARTIAL);
            check({crun, erun}, 2'b01);
            irqs(2'b00);
            feed(m[0]);
            irqs(2'b01);
            for (int a = 0; a < 32; a++) begin
                @(posedge pclk);
                ra <= 10'(a);
                @(negedge pclk);
                check(ok, (a >= 'h14 && a <= 'h1d) || a inside {0, 1, 3, 7, 'he, 'hf});
            end
        end
        go_mode(mpm_pkg::MPM_DETECT);
        irqs(2'b00);
        go_mode(mpm_pkg::MPM_IDLE);
        finish_test();
    end
endmodule
